/* File: hw/tropuf_pkg.sv */
// Constants and types for the transient ring cell unclonable function
`default_nettype none
package tropuf_pkg;
    localparam int unsigned CELLS_PER_GROUP = 64;
    localparam int unsigned SEL_W           = 6;
    localparam int unsigned CNT_W           = 10;
    localparam int unsigned DIFF_W          = CNT_W + 1;
    localparam int unsigned BITS_PER_CHAL   = 2;
    localparam int unsigned RESP_W          = 128;
    localparam int unsigned CLK_PERIOD_PS   = 5000;
    localparam int unsigned ACT_TIME_US     = 2;
    // Least time, rounded up to whole cycles
    localparam int unsigned ACT_CYCLES      = (ACT_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ACT_CNT_W       = 9;
    localparam int unsigned SETTLE_CYCLES   = 2;
    localparam int unsigned SETTLE_W        = 2;

    localparam logic [SEL_W-1:0]     LAST_CHAL     = 6'h3F;
    localparam logic [SEL_W-1:0]     FIRST_CHAL    = 6'h00;
    localparam logic [CNT_W-1:0]     CNT_ZERO      = 10'h000;
    localparam logic [CNT_W-1:0]     CNT_MAX       = 10'h3FF;
    localparam logic [ACT_CNT_W-1:0] ACT_LAST      = ACT_CNT_W'(ACT_CYCLES - 1);
    localparam logic [ACT_CNT_W-1:0] ACT_ZERO      = 9'h000;
    localparam logic [SETTLE_W-1:0]  SETTLE_LAST   = SETTLE_W'(SETTLE_CYCLES - 1);
    localparam logic [SETTLE_W-1:0]  SETTLE_ZERO   = 2'h0;
    localparam int unsigned          SIGN_BIT      = DIFF_W - 1;
    localparam int unsigned          LSB_BIT       = 0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECT,
        ST_ACTIVE,
        ST_SETTLE,
        ST_STROBE,
        ST_CLEAR
    } tropuf_state_type;

    // One challenge outcome: extracted bits plus raw subtraction
    typedef struct packed {
        logic [BITS_PER_CHAL-1:0] bits;
        logic [DIFF_W-1:0]        diff;
    } tropuf_result_type;
endpackage
`default_nettype wire

/* File: hw/tropuf_top.sv */
// Controller, counters and response register of the transient ring cell unclonable function
// Notes on behaviour
// R1 - There are 128 cells in two groups of 64, with two oscillation counters and one subtractor.
// R2 - Each challenge pairs one cell of group A with one of group B, and no cell is used twice.
// R3 - One demultiplexer per group enables the chosen cell and a multiplexer per group routes its output to its counter.
// R4 - Both chosen cells are started in the same cycle by one common activation signal.
// R5 - Each counter is 10 bits and counts oscillations of its chosen cell during the window.
// R6 - The subtractor compares the two counts and two response bits are taken from its result.
// R7 - A strobe output marks that the subtractor result is valid.
// R8 - After selection the activation signal is held at 1 for 2 us before the counts are sampled.
// R9 - At the end of the window activation drops, stopping both cells before the result is taken.
// R10 - After deactivation the strobe is generated.
// R11 - The sequence runs over all pairs and the bits are shifted into a 128-bit response register.
// R12 - After each strobe both counters are cleared before the next pair is selected.
`timescale 1ns/1ps
`default_nettype none
module tropuf_top (
    input  wire logic                                   CLK,
    input  wire logic                                   RESET_N,
    input  wire logic                                   START,
    input  wire logic [tropuf_pkg::CELLS_PER_GROUP-1:0] CELL_A_OUT,
    input  wire logic [tropuf_pkg::CELLS_PER_GROUP-1:0] CELL_B_OUT,
    output var  logic [tropuf_pkg::CELLS_PER_GROUP-1:0] CELL_A_ACT,
    output var  logic [tropuf_pkg::CELLS_PER_GROUP-1:0] CELL_B_ACT,
    output var  logic                                   BUSY,
    output var  logic                                   STROBE,
    output var  tropuf_pkg::tropuf_result_type          RESULT,
    output var  logic [tropuf_pkg::RESP_W-1:0]          RESPONSE,
    output var  logic                                   RESP_VALID,
    output var  logic                                   DONE
);

    tropuf_pkg::tropuf_state_type               state_r;
    tropuf_pkg::tropuf_state_type               state_nxt;
    logic [tropuf_pkg::SEL_W-1:0]               chal_r;
    logic [tropuf_pkg::ACT_CNT_W-1:0]           act_cnt_r;
    logic [tropuf_pkg::SETTLE_W-1:0]            settle_r;
    logic [tropuf_pkg::CNT_W-1:0]               cnt_a_r;
    logic [tropuf_pkg::CNT_W-1:0]               cnt_b_r;
    logic                                       prev_a_r;
    logic                                       prev_b_r;
    logic                                       sel_a;
    logic                                       sel_b;
    logic                                       counting;
    logic [tropuf_pkg::DIFF_W-1:0]              diff;

    // Saturating count: a stuck-fast cell must not wrap and flip the comparison
    function automatic logic [tropuf_pkg::CNT_W-1:0] count_step(
        input logic [tropuf_pkg::CNT_W-1:0] cnt,
        input logic                         prev,
        input logic                         cur
    );
        logic [tropuf_pkg::CNT_W-1:0] res;
        res = cnt;
        if (cur && !prev && cnt != tropuf_pkg::CNT_MAX) begin
            res = cnt + 1'b1;
        end
        return res;
    endfunction

    function automatic logic [tropuf_pkg::CELLS_PER_GROUP-1:0] one_hot(
        input logic [tropuf_pkg::SEL_W-1:0] idx
    );
        logic [tropuf_pkg::CELLS_PER_GROUP-1:0] res;
        res      = '0;
        res[idx] = 1'b1;
        return res;
    endfunction

    // R3 output multiplexers
    assign sel_a    = CELL_A_OUT[chal_r];
    assign sel_b    = CELL_B_OUT[chal_r];
    // Settle keeps counting edges already in flight after the cells stop
    assign counting = (state_r == tropuf_pkg::ST_ACTIVE) || (state_r == tropuf_pkg::ST_SETTLE);
    // R6 subtractor
    assign diff     = {1'b0, cnt_a_r} - {1'b0, cnt_b_r};
    assign BUSY     = (state_r != tropuf_pkg::ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tropuf_pkg::ST_IDLE: begin
                if (START) begin
                    state_nxt = tropuf_pkg::ST_SELECT;
                end
            end
            tropuf_pkg::ST_SELECT: begin
                state_nxt = tropuf_pkg::ST_ACTIVE;
            end
            tropuf_pkg::ST_ACTIVE: begin
                // R8 window length
                if (act_cnt_r == tropuf_pkg::ACT_LAST) begin
                    state_nxt = tropuf_pkg::ST_SETTLE;
                end
            end
            tropuf_pkg::ST_SETTLE: begin
                // R10 strobe after deactivation
                if (settle_r == tropuf_pkg::SETTLE_LAST) begin
                    state_nxt = tropuf_pkg::ST_STROBE;
                end
            end
            tropuf_pkg::ST_STROBE: begin
                state_nxt = tropuf_pkg::ST_CLEAR;
            end
            tropuf_pkg::ST_CLEAR: begin
                if (chal_r == tropuf_pkg::LAST_CHAL) begin
                    state_nxt = tropuf_pkg::ST_IDLE;
                end else begin
                    state_nxt = tropuf_pkg::ST_SELECT;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= tropuf_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // R2 each index used once, A[i] against B[i]
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chal_r <= tropuf_pkg::FIRST_CHAL;
        end else if (state_r == tropuf_pkg::ST_IDLE && START) begin
            chal_r <= tropuf_pkg::FIRST_CHAL;
        end else if (state_r == tropuf_pkg::ST_CLEAR && chal_r != tropuf_pkg::LAST_CHAL) begin
            chal_r <= chal_r + 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            act_cnt_r <= tropuf_pkg::ACT_ZERO;
            settle_r  <= tropuf_pkg::SETTLE_ZERO;
        end else begin
            act_cnt_r <= (state_r == tropuf_pkg::ST_ACTIVE) ? act_cnt_r + 1'b1 : tropuf_pkg::ACT_ZERO;
            settle_r  <= (state_r == tropuf_pkg::ST_SETTLE) ? settle_r + 1'b1 : tropuf_pkg::SETTLE_ZERO;
        end
    end

    // R4 R9 common activation, dropped when window ends
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            CELL_A_ACT <= '0;
            CELL_B_ACT <= '0;
        end else if (state_nxt == tropuf_pkg::ST_ACTIVE) begin
            // R3 demultiplexed enables
            CELL_A_ACT <= one_hot(chal_r);
            CELL_B_ACT <= one_hot(chal_r);
        end else begin
            CELL_A_ACT <= '0;
            CELL_B_ACT <= '0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
        end else begin
            prev_a_r <= sel_a;
            prev_b_r <= sel_b;
        end
    end

    // R5 R1 two oscillation counters
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_a_r <= tropuf_pkg::CNT_ZERO;
            cnt_b_r <= tropuf_pkg::CNT_ZERO;
        end else if (state_r == tropuf_pkg::ST_CLEAR || state_r == tropuf_pkg::ST_IDLE) begin
            // R12 clear after strobe
            cnt_a_r <= tropuf_pkg::CNT_ZERO;
            cnt_b_r <= tropuf_pkg::CNT_ZERO;
        end else if (counting) begin
            cnt_a_r <= count_step(cnt_a_r, prev_a_r, sel_a);
            cnt_b_r <= count_step(cnt_b_r, prev_b_r, sel_b);
        end
    end

    // R6 R7 two bits latched and strobed
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESULT <= '0;
            STROBE <= 1'b0;
        end else begin
            STROBE <= (state_nxt == tropuf_pkg::ST_STROBE);
            if (state_nxt == tropuf_pkg::ST_STROBE) begin
                RESULT.bits <= {diff[tropuf_pkg::SIGN_BIT], diff[tropuf_pkg::LSB_BIT]};
                RESULT.diff <= diff;
            end
        end
    end

    // R11 response shift register
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESPONSE <= '0;
        end else if (STROBE) begin
            RESPONSE <= {RESPONSE[tropuf_pkg::RESP_W-tropuf_pkg::BITS_PER_CHAL-1:0], RESULT.bits};
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RESP_VALID <= 1'b0;
            DONE       <= 1'b0;
        end else begin
            DONE <= (state_r == tropuf_pkg::ST_CLEAR) && (chal_r == tropuf_pkg::LAST_CHAL);
            if (state_r == tropuf_pkg::ST_IDLE && START) begin
                RESP_VALID <= 1'b0;
            end else if (state_r == tropuf_pkg::ST_CLEAR && chal_r == tropuf_pkg::LAST_CHAL) begin
                RESP_VALID <= 1'b1;
            end
        end
    end

endmodule // tropuf_top
`default_nettype wire

/* File: tb/tropuf_monitor.sv */
// Port checker for the transient ring cell unclonable function
`timescale 1ns/1ps
`default_nettype none
module tropuf_monitor (
    input wire logic         CLK,
    input wire logic         RESET_N,
    input wire logic [63:0]  CELL_A_ACT,
    input wire logic [63:0]  CELL_B_ACT,
    input wire logic         STROBE,
    input wire tropuf_pkg::tropuf_result_type RESULT,
    input wire logic [127:0] RESPONSE,
    input wire logic         RESP_VALID,
    input wire logic         DONE
);
    logic [9:0] act_len_r;
    wire logic  act_on;
    assign act_on = |CELL_A_ACT;
    // Counter, since 400 cycles is past any repetition
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            act_len_r <= 10'h000;
        else
            act_len_r <= act_on ? act_len_r + 10'h001 : 10'h000;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    a_pair_same: assert property (CELL_A_ACT == CELL_B_ACT)
        else $error("groups activated apart");
    a_one_cell: assert property ($onehot0(CELL_A_ACT))
        else $error("several cells active");
    a_window_len: assert property ($fell(act_on) |-> act_len_r == 10'h190)
        else $error("window length wrong");
    a_window_cap: assert property (act_on |-> act_len_r < 10'h190)
        else $error("window too long");
    a_strobe_after: assert property ($fell(act_on) |-> !STROBE ##1 !STROBE ##1 STROBE)
        else $error("strobe misplaced");
    a_strobe_idle: assert property (STROBE |-> !act_on)
        else $error("strobe while active");
    a_strobe_pulse: assert property (STROBE |=> !STROBE)
        else $error("strobe too long");
    a_bits_source: assert property (STROBE |-> RESULT.bits == {RESULT.diff[10], RESULT.diff[0]})
        else $error("bits not from difference");
    a_resp_shift: assert property (STROBE |=> RESPONSE == {$past(RESPONSE[125:0]), $past(RESULT.bits)})
        else $error("response not shifted");
    a_done_valid: assert property (DONE |-> RESP_VALID)
        else $error("done without valid");
endmodule // tropuf_monitor
bind tropuf_top tropuf_monitor mon (.CLK(CLK), .RESET_N(RESET_N), .CELL_A_ACT(CELL_A_ACT), .CELL_B_ACT(CELL_B_ACT),
    .STROBE(STROBE), .RESULT(RESULT), .RESPONSE(RESPONSE), .RESP_VALID(RESP_VALID), .DONE(DONE));
`default_nettype wire

/* File: tb/tropuf_cells.sv */
// Behavioural ring cells of both groups
`timescale 1ns/1ps
`default_nettype none
module tropuf_cells (
    input  wire logic        clk,
    input  wire logic [63:0] act_a,
    input  wire logic [63:0] act_b,
    input  wire logic [7:0]  seed_a,
    input  wire logic [7:0]  seed_b,
    output var  logic [63:0] out_a,
    output var  logic [63:0] out_b
);
    int k_a[64];
    int k_b[64];
    // Half period 1 to 13 cycles from cell index and seed; rest level low
    function automatic logic level(int i, logic [7:0] s, int k);
        return ((k / (1 + (i * 7 + s) % 13)) % 2) == 1;
    endfunction
    initial begin
        out_a = '0;
        out_b = '0;
    end
    always @(negedge clk) begin
        for (int i = 0; i < 64; i++) begin
            out_a[i] <= act_a[i] && level(i, seed_a, k_a[i]);
            out_b[i] <= act_b[i] && level(i, seed_b, k_b[i]);
            k_a[i] = act_a[i] ? k_a[i] + 1 : 0;
            k_b[i] = act_b[i] ? k_b[i] + 1 : 0;
        end
    end
endmodule // tropuf_cells
`default_nettype wire

/* File: tb/tropuf_bench.sv */
// Self-checking bench for the transient ring cell unclonable function
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tropuf_bench;
    logic        clk = 1'b0, reset_n = 1'b0, start = 1'b0;
    logic [63:0] a_out, b_out, a_act, b_act;
    logic        busy, strobe, resp_valid, done;
    logic [127:0] response;
    tropuf_pkg::tropuf_result_type result;
    logic [7:0]  seed_a = 8'h00, seed_b = 8'h00;
    int          miscompares = 0, n_tests = 0, cycles = 0;
    always #2.5 clk = ~clk;
    tropuf_top dut (.CLK(clk), .RESET_N(reset_n), .START(start), .CELL_A_OUT(a_out), .CELL_B_OUT(b_out),
        .CELL_A_ACT(a_act), .CELL_B_ACT(b_act), .BUSY(busy), .STROBE(strobe), .RESULT(result),
        .RESPONSE(response), .RESP_VALID(resp_valid), .DONE(done));
    tropuf_cells cells (.clk(clk), .act_a(a_act), .act_b(b_act), .seed_a(seed_a), .seed_b(seed_b),
        .out_a(a_out), .out_b(b_out));
    // Rising edges a cell gives in 400 active cycles
    function automatic logic [9:0] exp_cnt(int i, logic [7:0] s);
        return 10'(((399 / (1 + (i * 7 + s) % 13)) + 1) / 2);
    endfunction
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic run(logic [7:0] sa, logic [7:0] sb, logic keep);
        logic [127:0] er;
        logic [10:0]  d;
        int           t;
        er = '0;
        seed_a = sa;
        seed_b = sb;
        start = 1'b1;
        for (int i = 0; i < 64; i++) begin
            t = 0;
            do begin
                @(negedge clk);
                t++;
            end while (strobe !== 1'b1 && t < 600);
            `CHK("strobe", 1'b1, strobe)
            d = {1'b0, exp_cnt(i, sa)} - {1'b0, exp_cnt(i, sb)};
            `CHK("diff", d, result.diff)
            `CHK("bits", {d[10], d[0]}, result.bits)
            `CHK("busy valid", 2'b10, {busy, resp_valid})
            er = {er[125:0], d[10], d[0]};
        end
        // Held start must not restart a busy run
        start = keep;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (done !== 1'b1 && t < 20);
        `CHK("done", 1'b1, done)
        `CHK("response", er, response)
        `CHK("valid", 1'b1, resp_valid)
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(32'hBE07));
        repeat (8) @(negedge clk);
        `CHK("reset", 1'b0, |{busy, strobe, response, resp_valid, done, a_act, b_act, result})
        reset_n = 1'b1;
        run(8'($urandom), 8'($urandom), 1'b1);
        // Equal groups: every difference zero
        run(8'h5A, 8'h5A, 1'b0);
        start = 1'b1;
        repeat (1000) @(negedge clk);
        reset_n = 1'b0;
        @(negedge clk);
        `CHK("abort", 1'b0, |{busy, strobe, response, resp_valid, a_act})
        end_of_test();
    end
endmodule // tropuf_bench
`default_nettype wire
